// ---- wsdc_pkg.sv ----
// constants, field layout and state codes for the wideband synth divider control
// assumes one 200 MHz clock, a synchronous active-high reset and an AXI4-Lite master
// What this block does
// - a register write selects and strobes the latch holding divider data
// - reference divider divides the 8 MHz reference by 160 to 50 kHz
// - feedback divider divides by a programmed ratio from 80 to 160
// - feedback fast or leading: pump-down pulses low, pump-up stays high
// - feedback slow or lagging: pump-up pulses low, pump-down stays high
// - matched loop: both pump outputs high except a brief joint low pulse
// - feedback path prescales by two then by four, eight in total
// - divide-by-two gives top octave, counter taps give four lower octaves
// - three select lines pass one of five octaves to the output in the top range; codes 5 to 7 pass none
// - select lines decode into five filter enables and an isolation line
// - the matching filter turns on whenever its octave is selected
// - isolation line active for the two highest octaves only
// - power control low stops the reference generator and the oscillator
// - two low ranges use external oscillator, top range uses the synthesizer
// - lowest range with shunt bit set enables the sensor shunt
package wsdc_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_MHZ     = 200;
	localparam int unsigned REF_MHZ     = 8;
	localparam int unsigned COMP_KHZ    = 50;
	localparam logic [7:0]  REF_DIV     = 8'hA0;
	localparam logic [7:0]  FB_MIN      = 8'h50;
	localparam logic [7:0]  FB_MAX      = 8'hA0;
	localparam logic [7:0]  FB_RST      = 8'hA0;
	localparam int unsigned LOCK_WIN_NS = 100;
	localparam int unsigned LOCK_WIN_CY = (LOCK_WIN_NS * CLK_MHZ) / 1000;
	localparam logic [7:0]  LOCK_WIN    = 8'(LOCK_WIN_CY);

	////////////////////////////////////////////////////////////////////////////
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  RATIO_OFS   = 8'h04;
	localparam logic [7:0]  STAT_OFS    = 8'h08;
	localparam logic [7:0]  REFDIV_OFS  = 8'h0C;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam int unsigned CTRL_PWR    = 0;
	localparam int unsigned CTRL_FBS    = 1;
	localparam int unsigned CTRL_OCT    = 2;
	localparam int unsigned CTRL_SHUNT  = 5;
	localparam int unsigned CTRL_RNG    = 6;
	localparam int unsigned STAT_LOCK   = 0;
	localparam int unsigned STAT_UP_N   = 1;
	localparam int unsigned STAT_DN_N   = 2;
	localparam int unsigned STAT_PWR    = 3;
	localparam logic [2:0]  OCT_LAST    = 3'h4;
	localparam logic [2:0]  OCT_ISO_MAX = 3'h1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		RNG_LOW  = 2'h0,
		RNG_MID  = 2'h1,
		RNG_HIGH = 2'h2
	} wsdc_range_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wsdc_wr_st_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} wsdc_rd_st_t;

endpackage : wsdc_pkg

// ---- wsdc_pd_if.sv ----
// carries divided reference and feedback events to the phase detector and its outputs back
// assumes both ends sit on the same clock
interface wsdc_pd_if;
	logic ref_pulse;
	logic fb_pulse;
	logic pump_up_n;
	logic pump_down_n;
	logic locked;

	modport ctl (output ref_pulse, output fb_pulse,
		input pump_up_n, input pump_down_n, input locked);
	modport pd (input ref_pulse, input fb_pulse,
		output pump_up_n, output pump_down_n, output locked);
endinterface : wsdc_pd_if

// ---- wsdc_pfd.sv ----
// two-output phase/frequency detector with a lock flag
// assumes one-cycle event pulses many cycles apart, same clock as the caller
module wsdc_pfd
	import wsdc_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic srst_i,
	wsdc_pd_if.pd     pd
);

	logic       up_r,   up_nxt;
	logic       dn_r,   dn_nxt;
	logic       lock_r, lock_nxt;
	logic [7:0] win_r,  win_nxt;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		up_nxt   = up_r | pd.ref_pulse;
		dn_nxt   = dn_r | pd.fb_pulse;
		lock_nxt = lock_r;
		win_nxt  = win_r;
		if (up_r && dn_r) begin
			// both low for one cycle, then release; a new event still lands
			up_nxt   = pd.ref_pulse;
			dn_nxt   = pd.fb_pulse;
			lock_nxt = (win_r <= LOCK_WIN);
			win_nxt  = 8'h00;
		end else if ((up_r || dn_r) && win_r != 8'hFF) begin
			win_nxt = win_r + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			up_r   <= 1'b0;
			dn_r   <= 1'b0;
			lock_r <= 1'b0;
			win_r  <= 8'h00;
		end else begin
			up_r   <= up_nxt;
			dn_r   <= dn_nxt;
			lock_r <= lock_nxt;
			win_r  <= win_nxt;
		end
	end

	// pump-up follows the reference, pump-down the feedback
	assign pd.pump_up_n   = ~up_r;
	assign pd.pump_down_n = ~dn_r;
	assign pd.locked      = lock_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence idle_s;
		!up_r && !dn_r;
	endsequence

	pump_down_a: assert property (idle_s ##0 (pd.fb_pulse && !pd.ref_pulse) |=>
		!pd.pump_down_n && pd.pump_up_n)
		else $error("pump down did not pulse alone");
	pump_up_a: assert property (idle_s ##0 (pd.ref_pulse && !pd.fb_pulse) |=>
		!pd.pump_up_n && pd.pump_down_n)
		else $error("pump up did not pulse alone");
	joint_pulse_a: assert property ((!pd.pump_up_n && !pd.pump_down_n &&
		!pd.ref_pulse && !pd.fb_pulse) |=> pd.pump_up_n && pd.pump_down_n)
		else $error("joint low pulse lasted too long");

endmodule : wsdc_pfd

// ---- wsdc_top.sv ----
// wideband synth divider control: register slave, dividers, octave mux and filter decode
// assumes ref_clk_i and vco_i are asynchronous pins well below half of mclk_i
module wsdc_top
	import wsdc_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              srst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              ref_clk_i,
	input  wire logic              vco_i,
	output logic                   ref_clk_en_o,
	output logic                   vco_en_o,
	output logic                   module_power_n_o,
	output logic                   band_switch_ctl_o,
	output logic                   octave_sel_bit0_o,
	output logic                   octave_sel_bit1_o,
	output logic                   octave_sel_bit2_o,
	output logic [4:0]             filter_en_o,
	output logic                   high_octave_isolate_o,
	output logic                   synth_out_o,
	output logic                   synth_source_o,
	output logic                   pump_up_n_o,
	output logic                   pump_down_n_o,
	output logic                   sensor_shunt_ctl_o
);

	wsdc_pd_if pd_if ();

	wsdc_pfd u_pfd (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.pd     (pd_if.pd)
	);

	////////////////////////////////////////////////////////////////////////////
	// register slave
	wsdc_wr_st_t       wr_st_r,   wr_st_nxt;
	wsdc_rd_st_t       rd_st_r,   rd_st_nxt;
	logic              aw_got_r,  aw_got_nxt;
	logic              w_got_r,   w_got_nxt;
	logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
	logic [7:0]        wr_data_r, wr_data_nxt;
	logic              wr_be_r,   wr_be_nxt;
	logic [1:0]        bresp_r,   bresp_nxt;
	logic [31:0]       rdata_r,   rdata_nxt;
	logic [1:0]        rresp_r,   rresp_nxt;
	logic [7:0]        ctrl_r,    ctrl_nxt;
	logic [7:0]        ratio_r,   ratio_nxt;
	logic              wr_fire;
	logic              ratio_ok;
	logic              pwr_on;
	logic [2:0]        oct_code;
	wsdc_range_t       range_sel;

	assign pwr_on    = ctrl_r[CTRL_PWR];
	assign oct_code  = ctrl_r[CTRL_OCT +: 3];
	assign range_sel = wsdc_range_t'(ctrl_r[CTRL_RNG +: 2]);
	assign wr_fire   = (wr_st_r == WR_IDLE) && aw_got_r && w_got_r;
	assign ratio_ok  = (wr_data_r >= FB_MIN) && (wr_data_r <= FB_MAX);

	assign s_axi_awready_o = (wr_st_r == WR_IDLE) && !aw_got_r;
	assign s_axi_wready_o  = (wr_st_r == WR_IDLE) && !w_got_r;
	assign s_axi_bvalid_o  = (wr_st_r == WR_RESP);
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = (rd_st_r == RD_IDLE);
	assign s_axi_rvalid_o  = (rd_st_r == RD_DATA);
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;

	always_comb begin
		wr_st_nxt   = wr_st_r;
		aw_got_nxt  = aw_got_r;
		w_got_nxt   = w_got_r;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		wr_be_nxt   = wr_be_r;
		bresp_nxt   = bresp_r;
		ctrl_nxt    = ctrl_r;
		ratio_nxt   = ratio_r;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_got_nxt  = 1'b1;
			wr_addr_nxt = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_got_nxt   = 1'b1;
			wr_data_nxt = s_axi_wdata_i[7:0];
			wr_be_nxt   = s_axi_wstrb_i[0];
		end
		unique case (wr_st_r)
			WR_IDLE: begin
				if (wr_fire) begin
					wr_st_nxt = WR_RESP;
					bresp_nxt = RESP_OKAY;
					unique case (wr_addr_r)
						CTRL_OFS: begin
							if (wr_be_r) ctrl_nxt = wr_data_r;
						end
						// address decode plus write forms the latch strobe
						RATIO_OFS: begin
							if (wr_be_r && ratio_ok) ratio_nxt = wr_data_r;
						end
						STAT_OFS, REFDIV_OFS: bresp_nxt = RESP_OKAY;
						default: bresp_nxt = RESP_SLVERR;
					endcase
				end
			end
			WR_RESP: begin
				if (s_axi_bready_i) begin
					wr_st_nxt  = WR_IDLE;
					aw_got_nxt = 1'b0;
					w_got_nxt  = 1'b0;
				end
			end
		endcase
	end

	always_comb begin
		rd_st_nxt = rd_st_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		unique case (rd_st_r)
			RD_IDLE: begin
				if (s_axi_arvalid_i) begin
					rd_st_nxt = RD_DATA;
					rresp_nxt = RESP_OKAY;
					rdata_nxt = 32'h0000_0000;
					unique case (s_axi_araddr_i)
						CTRL_OFS:   rdata_nxt[7:0] = ctrl_r;
						RATIO_OFS:  rdata_nxt[7:0] = ratio_r;
						STAT_OFS: begin
							rdata_nxt[STAT_LOCK] = pd_if.locked;
							rdata_nxt[STAT_UP_N] = pd_if.pump_up_n;
							rdata_nxt[STAT_DN_N] = pd_if.pump_down_n;
							rdata_nxt[STAT_PWR]  = pwr_on;
						end
						REFDIV_OFS: rdata_nxt[7:0] = REF_DIV;
						default:    rresp_nxt = RESP_SLVERR;
					endcase
				end
			end
			RD_DATA: begin
				if (s_axi_rready_i) rd_st_nxt = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wr_st_r   <= WR_IDLE;
			rd_st_r   <= RD_IDLE;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= 8'h00;
			wr_be_r   <= 1'b0;
			bresp_r   <= RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OKAY;
			ctrl_r    <= CTRL_RST;
			ratio_r   <= FB_RST;
		end else begin
			wr_st_r   <= wr_st_nxt;
			rd_st_r   <= rd_st_nxt;
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
			wr_be_r   <= wr_be_nxt;
			bresp_r   <= bresp_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			ctrl_r    <= ctrl_nxt;
			ratio_r   <= ratio_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; third stage only feeds edge detection
	logic ref_s1_r, ref_s2_r, ref_s3_r;
	logic vco_s1_r, vco_s2_r, vco_s3_r;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			{ref_s1_r, ref_s2_r, ref_s3_r} <= 3'h0;
			{vco_s1_r, vco_s2_r, vco_s3_r} <= 3'h0;
		end else begin
			{ref_s1_r, ref_s2_r, ref_s3_r} <= {ref_clk_i, ref_s1_r, ref_s2_r};
			{vco_s1_r, vco_s2_r, vco_s3_r} <= {vco_i, vco_s1_r, vco_s2_r};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// dividers; all held cleared while the module is powered down
	logic [7:0] ref_cnt_r, ref_cnt_nxt;
	logic       ref_pls_r, ref_pls_nxt;
	logic       div2_r,    div2_nxt;
	logic [3:0] cnt4_r,    cnt4_nxt;
	logic [7:0] fb_cnt_r,  fb_cnt_nxt;
	logic       fb_pls_r,  fb_pls_nxt;
	logic       ref_rise, vco_rise, pre_edge;

	assign ref_rise = ref_s2_r & ~ref_s3_r;
	assign vco_rise = vco_s2_r & ~vco_s3_r;
	// counter bit 1 rising marks the divide-by-eight feedback edge
	assign pre_edge = vco_rise && !div2_r && (cnt4_r[1:0] == 2'b01);

	always_comb begin
		ref_cnt_nxt = ref_cnt_r;
		ref_pls_nxt = 1'b0;
		div2_nxt    = div2_r;
		cnt4_nxt    = cnt4_r;
		fb_cnt_nxt  = fb_cnt_r;
		fb_pls_nxt  = 1'b0;
		if (!pwr_on) begin
			ref_cnt_nxt = 8'h00;
			div2_nxt    = 1'b0;
			cnt4_nxt    = 4'h0;
			fb_cnt_nxt  = 8'h00;
		end else begin
			if (ref_rise) begin
				if (ref_cnt_r == REF_DIV - 8'h01) begin
					ref_cnt_nxt = 8'h00;
					ref_pls_nxt = 1'b1;
				end else begin
					ref_cnt_nxt = ref_cnt_r + 8'h01;
				end
			end
			if (vco_rise) begin
				div2_nxt = ~div2_r;
				if (!div2_r) cnt4_nxt = cnt4_r + 4'h1;
			end
			if (pre_edge) begin
				// ratio may shrink mid-count; wrap at once rather than overrun
				if (fb_cnt_r >= ratio_r - 8'h01) begin
					fb_cnt_nxt = 8'h00;
					fb_pls_nxt = 1'b1;
				end else begin
					fb_cnt_nxt = fb_cnt_r + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ref_cnt_r <= 8'h00;
			ref_pls_r <= 1'b0;
			div2_r    <= 1'b0;
			cnt4_r    <= 4'h0;
			fb_cnt_r  <= 8'h00;
			fb_pls_r  <= 1'b0;
		end else begin
			ref_cnt_r <= ref_cnt_nxt;
			ref_pls_r <= ref_pls_nxt;
			div2_r    <= div2_nxt;
			cnt4_r    <= cnt4_nxt;
			fb_cnt_r  <= fb_cnt_nxt;
			fb_pls_r  <= fb_pls_nxt;
		end
	end

	assign pd_if.ref_pulse = ref_pls_r;
	assign pd_if.fb_pulse  = fb_pls_r;

	////////////////////////////////////////////////////////////////////////////
	// octave mux and filter decode
	logic       synth_r, synth_nxt;
	logic [4:0] filt_r,  filt_nxt;
	logic       iso_r,   iso_nxt;
	logic [4:0] taps;

	assign taps = {cnt4_r, div2_r};

	always_comb begin
		synth_nxt = 1'b0;
		filt_nxt  = 5'h00;
		iso_nxt   = 1'b0;
		if (oct_code <= OCT_LAST) begin
			filt_nxt = 5'(5'h01 << oct_code);
			iso_nxt  = (oct_code <= OCT_ISO_MAX);
			if (pwr_on && range_sel == RNG_HIGH)
				synth_nxt = taps[oct_code];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			synth_r <= 1'b0;
			filt_r  <= 5'h00;
			iso_r   <= 1'b0;
		end else begin
			synth_r <= synth_nxt;
			filt_r  <= filt_nxt;
			iso_r   <= iso_nxt;
		end
	end

	assign synth_out_o           = synth_r;
	assign filter_en_o           = filt_r;
	assign high_octave_isolate_o = iso_r;
	assign ref_clk_en_o          = pwr_on;
	assign vco_en_o              = pwr_on;
	assign module_power_n_o      = pwr_on;
	assign band_switch_ctl_o     = ctrl_r[CTRL_FBS];
	assign octave_sel_bit0_o     = oct_code[0];
	assign octave_sel_bit1_o     = oct_code[1];
	assign octave_sel_bit2_o     = oct_code[2];
	assign synth_source_o        = (range_sel == RNG_HIGH);
	assign sensor_shunt_ctl_o    = ctrl_r[CTRL_SHUNT] && (range_sel == RNG_LOW);
	assign pump_up_n_o           = pd_if.pump_up_n;
	assign pump_down_n_o         = pd_if.pump_down_n;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	ref_div_a: assert property (ref_pls_r |-> $past(ref_cnt_r) == REF_DIV - 8'h01)
		else $error("reference pulse not at count 159");
	ratio_range_a: assert property (ratio_r >= FB_MIN && ratio_r <= FB_MAX)
		else $error("feedback ratio out of range");
	ratio_hold_a: assert property ((wr_fire && wr_addr_r == RATIO_OFS && !ratio_ok)
		|=> $stable(ratio_r))
		else $error("out of range ratio was taken");
	latch_strobe_a: assert property (!$stable(ratio_r) |-> $past(wr_fire))
		else $error("ratio changed without a write strobe");
	prescale_a: assert property (fb_pls_r |-> $past(cnt4_r[1:0], 2) == 2'b01)
		else $error("feedback edge not on counter bit one");
	top_octave_a: assert property ((oct_code == 3'h0 && pwr_on && range_sel == RNG_HIGH)
		|=> synth_r == $past(div2_r))
		else $error("top octave not routed");
	filter_dec_a: assert property ((oct_code > OCT_LAST) |=> filt_r == 5'h00 && !synth_r)
		else $error("illegal select code not disabled");
	filter_match_a: assert property ((oct_code <= OCT_LAST) |=> $onehot(filt_r) &&
		filt_r[$past(oct_code)])
		else $error("wrong filter enabled");
	isolate_a: assert property (iso_r == (filt_r[0] || filt_r[1]))
		else $error("isolation line mismatched");
	// enables follow the power bit at once; divider events die one edge later
	power_off_a: assert property (!pwr_on |-> (!vco_en_o && !ref_clk_en_o) ##1
		(!ref_pls_r && !fb_pls_r))
		else $error("dividers run while powered down");
	shunt_a: assert property (sensor_shunt_ctl_o |-> range_sel == RNG_LOW)
		else $error("shunt outside lowest range");

endmodule : wsdc_top

// ---- wsdc_src.sv ----
// stand-in for the far side: 8 MHz reference pin and a fixed 40 MHz oscillator
// assumes the enables come from the block under test
module wsdc_src
(
	input  wire logic ref_en_i,
	input  wire logic vco_en_i,
	output logic      ref_clk_o,
	output logic      vco_o
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_o = 1'b0;
		forever begin
			if (ref_en_i === 1'b1) #62.5 ref_clk_o = ~ref_clk_o;
			else begin
				ref_clk_o = 1'b0; // stopped generator idles low
				wait (ref_en_i === 1'b1);
			end
		end
	end
	initial begin
		vco_o = 1'b0;
		forever begin
			if (vco_en_i === 1'b1) #12.5 vco_o = ~vco_o;
			else begin
				vco_o = 1'b0; // oscillator stops dead
				wait (vco_en_i === 1'b1);
			end
		end
	end
endmodule : wsdc_src

// ---- wideband_synth_divider_control_bench.sv ----
// self-checking bench for the synth divider control
// assumes wsdc_top, wsdc_pkg and the wsdc_src stand-in are compiled first
module wideband_synth_divider_control_bench;
	import wsdc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [4:0]  fen;
	logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic        arready, rvalid, ref_clk, vco, ref_en, vco_en, pwr_n, fbs, ob0, ob1;
	logic        ob2, iso, sout, ssrc, up_n, dn_n, shunt;
	int          failures = 0;
	int          checks_done = 0;
	////////////////////////////////////////////////////////////////////////////
	initial forever #2.5 mclk_i = ~mclk_i;
	wsdc_top i_wsdc_top (.mclk_i(mclk_i), .srst_i(srst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ref_clk_i(ref_clk),
		.vco_i(vco), .ref_clk_en_o(ref_en), .vco_en_o(vco_en), .module_power_n_o(pwr_n),
		.band_switch_ctl_o(fbs), .octave_sel_bit0_o(ob0), .octave_sel_bit1_o(ob1),
		.octave_sel_bit2_o(ob2), .filter_en_o(fen), .high_octave_isolate_o(iso),
		.synth_out_o(sout), .synth_source_o(ssrc), .pump_up_n_o(up_n),
		.pump_down_n_o(dn_n), .sensor_shunt_ctl_o(shunt));
	wsdc_src i_wsdc_src (.ref_en_i(ref_en), .vco_en_i(vco_en), .ref_clk_o(ref_clk),
		.vco_o(vco));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic hung();
		failures++;
		$display("Error %0t: wait ran out", $time);
		give_verdict();
	endtask : hung
	task automatic rst();
		srst_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
	endtask : rst
	// entered just after a rising edge; both items offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic pa, pw, ra, rw, b;
		logic [1:0] r;
		int n;
		pa = 1'b1;
		pw = 1'b1;
		b = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw || !b) begin
			@(negedge mclk_i);
			ra = awready;
			rw = wready;
			b = !pa && !pw && bvalid === 1'b1;
			r = bresp;
			@(posedge mclk_i);
			if (pa && ra === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && rw === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			if (++n > 200) hung();
		end
		bready <= 1'b0;
		chk(r, er, "write response");
		// one idle edge so a following call never re-raises bready in this step
		@(posedge mclk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic pa, b;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		pa = 1'b1;
		b = 1'b0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pa || !b) begin
			@(negedge mclk_i);
			b = !pa && rvalid === 1'b1;
			d = rdata;
			r = rresp;
			if (arready === 1'b1 && pa) begin
				@(posedge mclk_i);
				pa = 1'b0;
				arvalid <= 1'b0;
			end
			else @(posedge mclk_i);
			if (++n > 200) hung();
		end
		rready <= 1'b0;
		chk(r, er, "read response");
		if (er === RESP_OKAY) chk(d, ed, "read data");
		@(posedge mclk_i);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] rv[5] = '{8'h4f, 8'h50, 8'ha1, 8'ha0, 8'h00};
		logic [7:0] ex[5] = '{8'ha0, 8'h50, 8'h50, 8'ha0, 8'ha0};
		rd(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		rd(RATIO_OFS, {24'h0, FB_RST}, RESP_OKAY);
		rd(STAT_OFS, 32'h0000_0006, RESP_OKAY);
		wr(REFDIV_OFS, 32'h0000_0005, 4'hf, RESP_OKAY);
		rd(REFDIV_OFS, 32'h0000_00a0, RESP_OKAY);
		wr(8'h10, 32'h0000_0001, 4'hf, RESP_SLVERR);
		rd(8'h10, 32'h0000_0000, RESP_SLVERR);
		for (int i = 0; i < 5; i++) begin
			wr(RATIO_OFS, {24'h0, rv[i]}, 4'hf, RESP_OKAY);
			rd(RATIO_OFS, {24'h0, ex[i]}, RESP_OKAY);
		end
		wr(RATIO_OFS, 32'h0000_0050, 4'h0, RESP_OKAY);
		rd(RATIO_OFS, 32'h0000_00a0, RESP_OKAY);
	endtask : t_regs
	// rising edges of the octave output over a 16 us window
	task automatic t_oct();
		int n, e;
		logic p;
		for (int c = 0; c < 8; c++) begin
			wr(CTRL_OFS, 32'h0000_0081 | (c << 2), 4'hf, RESP_OKAY);
			repeat (2) @(posedge mclk_i);
			chk({ob2, ob1, ob0}, c, "octave select");
			chk(fen, (c <= 4) ? (32'h1 << c) : 32'h0, "filter enables");
			chk(iso, c <= 1, "isolation line");
			chk({ref_en, vco_en, pwr_n, ssrc}, 4'hf, "powered top range");
			n = 0;
			p = sout;
			repeat (3200) begin
				@(negedge mclk_i);
				if (sout === 1'b1 && p === 1'b0) n++;
				p = sout;
			end
			@(posedge mclk_i);
			e = (c <= 4) ? (640 >> (c + 1)) : 0;
			chk(n >= e - 2 && n <= e + 2, 1'b1, "octave rate");
		end
	endtask : t_oct
	task automatic t_rng();
		for (int r = 0; r < 3; r++) begin
			wr(CTRL_OFS, (r << 6) | 32'h0000_0023, 4'hf, RESP_OKAY);
			repeat (2) @(posedge mclk_i);
			chk({ssrc, shunt, fbs}, {r == 2, r == 0, 1'b1}, "range pins");
		end
		wr(CTRL_OFS, 32'h0000_0080, 4'hf, RESP_OKAY);
		repeat (40) @(posedge mclk_i);
		chk({ref_en, vco_en, pwr_n, sout, fbs}, 5'h00, "powered down");
	endtask : t_rng
	// kind 0 feedback slow, 1 feedback fast, 2 matched
	task automatic t_pll(input logic [7:0] ratio, input int kind);
		int u, d, b;
		rst();
		wr(RATIO_OFS, {24'h0, ratio}, 4'hf, RESP_OKAY);
		wr(CTRL_OFS, 32'h0000_0081, 4'hf, RESP_OKAY);
		u = 0;
		d = 0;
		b = 0;
		repeat (14000) begin
			@(negedge mclk_i);
			if (up_n === 1'b0 && dn_n === 1'b1) u++;
			if (up_n === 1'b1 && dn_n === 1'b0) d++;
			if (up_n === 1'b0 && dn_n === 1'b0) b++;
		end
		@(posedge mclk_i);
		if (kind == 0) chk(u > 0 && d == 0, 1'b1, "slow feedback");
		if (kind == 1) chk(d > 0 && u == 0, 1'b1, "fast feedback");
		chk(b > 0, 1'b1, "joint low pulse");
		// ~70 us after power-on: matched loop locked with both pumps idle,
		// slow loop idle and unlocked, fast loop holding pump-down low
		rd(STAT_OFS, (kind == 2) ? 32'h0000_000f : (kind == 1) ? 32'h0000_000a : 32'h0000_000e,
			RESP_OKAY);
	endtask : t_pll
	////////////////////////////////////////////////////////////////////////////
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		rst();
		t_regs();
		t_oct();
		t_rng();
		t_pll(8'ha0, 0);
		t_pll(8'h50, 1);
		t_pll(8'h64, 2);
		give_verdict();
	end
endmodule : wideband_synth_divider_control_bench
